// file: logic/snooze_acquisition_sequencer.sv
`timescale 1ns/100ps
// How it works
// - In standby, a snooze is entered every thirty minutes to measure.
// - Snooze converts and judges level, then returns to standby without a hit.
// - A sample at or above threshold abandons snooze for normal run mode.
// - Every twenty-four hours low power ends and the buffer is transmitted.
// - A button press ends low power and transmits the measurement data.
// - Wake timer underflow starts conversion; results go to the measurement buffer.
// - Cascaded mode: first sixteen-bit stage underflows once per minute.
// - Second stage counts minute pulses and requests snooze after thirty counts.
// - Wide mode: one thirty-two-bit timer requests snooze every thirty minutes.
// - Conversion starts from the router trigger: underflow or snooze request event.
// - Four chained moves: ch0 buffer, ch1 buffer, threshold setting, ch1 compare input.
// - Buffer pointer wraps; later moves chain without a new trigger.
// - Comparator subtracts threshold and flags samples at or above it.
// - Transfer-complete event ends snooze; without a hit it returns to standby.
// - Alarm, external or compare interrupt wakes, transmits, returns to low power.
// - After an alarm wake the next alarm is programmed before sleeping.
// - Without calendar, a daily timer drives the output pin looped to an interrupt.
// - Router selects events for the processor and for the transfer engine.
module snooze_acquisition_sequencer
    import snooze_seq_pkg::*;
#(
    parameter logic [16:0] PRESCALE = 17'(PRESCALE_CYCLES),
    parameter logic [15:0] MINUTE_LEN = 16'(MINUTE_TICKS),
    parameter logic [31:0] WIDE_LEN = 32'(WIDE_TICKS),
    parameter logic [31:0] DAILY_LEN = 32'(DAILY_TICKS)
) (
    // Clock and reset.
    input wire logic sys_clk_i,
    input wire logic reset_i,
    // Mode straps.
    input wire logic wide_timer_mode_i,
    input wire logic calendar_present_i,
    input wire logic trig_on_snooze_req_i,
    // Interrupt router selections.
    input wire logic [EV_N-1:0] cpu_irq_enable_i,
    input wire logic xfer_trig_enable_i,
    // Wake sources.
    input wire logic alarm_i,
    input wire logic button_irq_i,
    input wire logic external_interrupt_line_two_i,
    // Analog converter.
    output logic conv_start_o,
    input wire logic conv_end_i,
    input wire logic [SAMPLE_W-1:0] ch0_result_i,
    input wire logic [SAMPLE_W-1:0] ch1_result_i,
    input wire logic [SAMPLE_W-1:0] threshold_i,
    // Serial comm unit transmit stream.
    output logic tx_valid_o,
    output logic [SAMPLE_W-1:0] tx_data_o,
    input wire logic tx_ready_i,
    // Status and event outputs.
    output logic [1:0] power_state_o,
    output logic transfer_done_event_o,
    output logic level_hit_o,
    output logic [SAMPLE_W-1:0] cmp_setting_o,
    output logic [EV_N-1:0] cpu_irq_o,
    output logic alarm_rearm_o,
    output logic timer_output_pin_o
);

    typedef struct packed {
        seq_state_t st;
        logic [1:0] pwr;
        logic [16:0] pre;
        logic tick;
        logic [15:0] min_cnt;
        logic [4:0] hh_cnt;
        logic [31:0] wide_cnt;
        logic [31:0] day_cnt;
        logic pin;
        logic conv_start;
        logic [SAMPLE_W-1:0] res0;
        logic [SAMPLE_W-1:0] res1;
        logic [1:0] move;
        logic [BUF_AW-1:0] wp;
        logic [BUF_AW:0] fill;
        logic [BUF_DEPTH-1:0][SAMPLE_W-1:0] buf0;
        logic [BUF_DEPTH-1:0][SAMPLE_W-1:0] buf1;
        logic [SAMPLE_W-1:0] cmp_set;
        logic [SAMPLE_W-1:0] cmp_in;
        logic hit;
        logic xfer_done;
        logic [EV_N-1:0] irq;
        logic ext1_prev;
        logic ext2_prev;
        logic wake_alarm;
        logic [BUF_AW+1:0] didx;
        logic tx_valid;
        logic [SAMPLE_W-1:0] tx_data;
        logic rearm;
        // Set on snooze entry when the converter waits for the routed request event.
        logic conv_pending;
    } seq_t;

    seq_t s_q;
    seq_t s_d;

    // Level compare unit: subtraction mode, no borrow means at or above.
    // The borrow bit of the widened difference is the below-threshold flag.
    function automatic logic at_or_above(input logic [SAMPLE_W-1:0] a, input logic [SAMPLE_W-1:0] b);
        logic [SAMPLE_W:0] diff;
        diff = {1'b0, a} - {1'b0, b};
        return ~diff[SAMPLE_W];
    endfunction

    logic minute_uf;
    logic snooze_req;
    logic daily_uf;
    logic ext1_edge;
    logic ext2_edge;
    logic cmp_now;
    logic wake_now;
    logic [EV_N-1:0] events;

    // Timer underflows and edge-detected wake requests.
    always_comb begin
        minute_uf = s_q.tick && (s_q.min_cnt == 16'h0000);
        // Wide mode takes the request from one long counter, else from the cascade.
        snooze_req = wide_timer_mode_i ? (s_q.tick && (s_q.wide_cnt == 32'h0000))
                                       : (minute_uf && (s_q.hh_cnt == 5'h00));
        daily_uf = s_q.tick && (s_q.day_cnt == 32'h0000);
        ext1_edge = button_irq_i && !s_q.ext1_prev;
        ext2_edge = external_interrupt_line_two_i && !s_q.ext2_prev;
        cmp_now = (s_q.st == ST_XFER) && (s_q.move == MOVE_CMP_IN) && at_or_above(s_q.res1, s_q.cmp_set);
        // The daily wake comes from the alarm with a calendar, else from the looped pin.
        wake_now = (calendar_present_i && alarm_i) || ext1_edge || (!calendar_present_i && ext2_edge);
        // Raw events feed the interrupt router, which registers them under the mask.
        events = '0;
        events[EV_SNOOZE_REQ] = snooze_req;
        events[EV_CONV_END] = conv_end_i;
        events[EV_XFER_DONE] = s_q.xfer_done;
        events[EV_CMP_HIT] = cmp_now;
        events[EV_ALARM] = alarm_i;
        events[EV_EXT_ONE] = ext1_edge;
        events[EV_EXT_TWO] = ext2_edge;
    end

    // Next-state logic for timers, acquisition sequence and data dump.
    always_comb begin
        s_d = s_q;
        // Pulses default low each cycle; edge detectors follow their pins.
        s_d.conv_start = 1'b0;
        s_d.xfer_done = 1'b0;
        s_d.rearm = 1'b0;
        s_d.pin = 1'b0;
        s_d.ext1_prev = button_irq_i;
        s_d.ext2_prev = external_interrupt_line_two_i;
        s_d.irq = events & cpu_irq_enable_i;

        // Prescaler gives a one-cycle tick that paces every timer.
        s_d.tick = (s_q.pre == 17'h00000);
        s_d.pre = s_d.tick ? PRESCALE - 17'h00001 : s_q.pre - 17'h00001;
        // Counters load zero at reset, so every timer underflows on the first tick.
        // Later periods are full; the first snooze therefore follows reset at once.
        if (s_q.tick) begin
            s_d.min_cnt = (s_q.min_cnt == 16'h0000) ? MINUTE_LEN - 16'h0001 : s_q.min_cnt - 16'h0001;
            s_d.wide_cnt = (s_q.wide_cnt == 32'h0000) ? WIDE_LEN - 32'h00000001 : s_q.wide_cnt - 32'h00000001;
            s_d.day_cnt = (s_q.day_cnt == 32'h0000) ? DAILY_LEN - 32'h00000001 : s_q.day_cnt - 32'h00000001;
        end
        if (minute_uf) begin
            s_d.hh_cnt = (s_q.hh_cnt == 5'h00) ? HALF_HOUR_COUNTS - 5'h01 : s_q.hh_cnt - 5'h01;
        end
        // Daily timer pulses the output pin when no calendar alarm exists.
        if (!calendar_present_i && daily_uf) begin
            s_d.pin = 1'b1;
        end

        // Sequence: standby, convert, chained transfer, then standby or a data dump.
        // Only the standby branch decodes a snooze request, so none restarts a sequence.
        case (s_q.st)
            ST_STANDBY: begin
                s_d.pwr = PWR_STANDBY;
                // A wake source wins over a snooze request of the same cycle.
                if (wake_now) begin
                    s_d.st = ST_DUMP;
                    s_d.pwr = PWR_NORMAL;
                    s_d.wake_alarm = calendar_present_i && alarm_i;
                    s_d.didx = '0;
                end else if (snooze_req) begin
                    s_d.st = ST_CONVERT;
                    s_d.pwr = PWR_SNOOZE;
                    // With request routing the start waits for the registered request event.
                    s_d.conv_start = !trig_on_snooze_req_i;
                    s_d.conv_pending = trig_on_snooze_req_i;
                end
            end
            ST_CONVERT: begin
                // A wake source wins over a conversion start or end in the same cycle.
                if (wake_now) begin
                    s_d.st = ST_DUMP;
                    s_d.pwr = PWR_NORMAL;
                    s_d.wake_alarm = calendar_present_i && alarm_i;
                    s_d.didx = '0;
                    s_d.conv_pending = 1'b0;
                end else begin
                    // The pending flag lets only the entry request start the converter.
                    if (s_q.conv_pending && s_q.irq[EV_SNOOZE_REQ]) begin
                        s_d.conv_start = 1'b1;
                        s_d.conv_pending = 1'b0;
                    end
                    // Conversion end hands both results to the chained transfer engine.
                    if (conv_end_i && xfer_trig_enable_i) begin
                        s_d.st = ST_XFER;
                        s_d.res0 = ch0_result_i;
                        s_d.res1 = ch1_result_i;
                        s_d.move = MOVE_CH0;
                    end
                end
            end
            ST_XFER: begin
                // One chained move per cycle, no fresh trigger between them.
                s_d.move = s_q.move + 2'h1;
                case (s_q.move)
                    MOVE_CH0: s_d.buf0[s_q.wp] = s_q.res0;
                    // The second move advances the pointer so the buffer wraps after the last slot.
                    MOVE_CH1: begin
                        s_d.buf1[s_q.wp] = s_q.res1;
                        s_d.wp = s_q.wp + 1'b1;
                        if (s_q.fill != 4'(BUF_DEPTH)) begin
                            s_d.fill = s_q.fill + 1'b1;
                        end
                    end
                    // The threshold is sampled from its pin in the third move.
                    MOVE_THRESH: s_d.cmp_set = threshold_i;
                    // The last move closes the chain and raises the transfer-done event.
                    default: begin
                        s_d.cmp_in = s_q.res1;
                        s_d.hit = cmp_now;
                        s_d.xfer_done = 1'b1;
                        s_d.move = MOVE_CH0;
                        // A hit abandons snooze and dumps the buffer at once.
                        if (cmp_now) begin
                            s_d.st = ST_DUMP;
                            s_d.pwr = PWR_NORMAL;
                            s_d.wake_alarm = 1'b0;
                            s_d.didx = '0;
                        end else begin
                            s_d.st = ST_STANDBY;
                            s_d.pwr = PWR_STANDBY;
                        end
                    end
                endcase
            end
            ST_DUMP: begin
                // Stream ch0 and ch1 entries pairwise, from slot zero up to the fill count.
                // A word stands until the receiver takes it; the next follows after one idle cycle.
                if (s_q.tx_valid) begin
                    if (tx_ready_i) begin
                        s_d.tx_valid = 1'b0;
                        s_d.didx = s_q.didx + 1'b1;
                    end
                end else if (s_q.didx[BUF_AW+1:1] < s_q.fill) begin
                    s_d.tx_valid = 1'b1;
                    s_d.tx_data = s_q.didx[0] ? s_q.buf1[s_q.didx[BUF_AW:1]] : s_q.buf0[s_q.didx[BUF_AW:1]];
                end else begin
                    // After an alarm wake the next alarm is programmed while still awake.
                    s_d.st = s_q.wake_alarm ? ST_REARM : ST_STANDBY;
                    s_d.pwr = s_q.wake_alarm ? PWR_NORMAL : PWR_STANDBY;
                    s_d.rearm = s_q.wake_alarm;
                end
            end
            ST_REARM: begin
                // Clearing the alarm flag keeps a later wake from rearming again.
                s_d.wake_alarm = 1'b0;
                s_d.st = ST_STANDBY;
                s_d.pwr = PWR_STANDBY;
            end
            default: begin
                // An unused state code falls back to standby.
                s_d.st = ST_STANDBY;
                s_d.pwr = PWR_STANDBY;
            end
        endcase
    end

    // State register.
    // Reset loads constants only; the whole state is one register.
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            s_q <= '0;
            s_q.st <= ST_STANDBY;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs come straight from the state register.
    // No output passes through logic after the register.
    assign conv_start_o = s_q.conv_start;
    assign tx_valid_o = s_q.tx_valid;
    assign tx_data_o = s_q.tx_data;
    assign power_state_o = s_q.pwr;
    assign transfer_done_event_o = s_q.xfer_done;
    assign level_hit_o = s_q.hit;
    assign cmp_setting_o = s_q.cmp_set;
    assign cpu_irq_o = s_q.irq;
    assign alarm_rearm_o = s_q.rearm;
    assign timer_output_pin_o = s_q.pin;

endmodule

// file: inc/snooze_seq_pkg.sv
package snooze_seq_pkg;

    // System clock and the slow tick that paces every wake timer.
    localparam int unsigned CLK_HZ = 125_000_000;
    localparam int unsigned TICK_HZ = 1000;
    localparam int unsigned PRESCALE_CYCLES = CLK_HZ / TICK_HZ;

    // Wake periods in their own units.
    localparam int unsigned MINUTE_S = 60;
    localparam int unsigned HALF_HOUR_MIN = 30;
    localparam int unsigned DAY_H = 24;

    // Derived tick counts for the timer stages.
    localparam int unsigned MINUTE_TICKS = MINUTE_S * TICK_HZ;
    localparam int unsigned WIDE_TICKS = HALF_HOUR_MIN * MINUTE_S * TICK_HZ;
    localparam int unsigned DAILY_TICKS = DAY_H * 60 * MINUTE_S * TICK_HZ;
    localparam logic [4:0] HALF_HOUR_COUNTS = 5'h1e;

    // Sample and measurement buffer geometry.
    localparam int SAMPLE_W = 12;
    localparam int BUF_DEPTH = 8;
    localparam int BUF_AW = 3;

    // Event numbering shared by the interrupt router inputs and outputs.
    localparam int EV_N = 7;
    localparam int EV_SNOOZE_REQ = 0;
    localparam int EV_CONV_END = 1;
    localparam int EV_XFER_DONE = 2;
    localparam int EV_CMP_HIT = 3;
    localparam int EV_ALARM = 4;
    localparam int EV_EXT_ONE = 5;
    localparam int EV_EXT_TWO = 6;

    // Power state encoding shown on the mode output.
    localparam logic [1:0] PWR_STANDBY = 2'h0;
    localparam logic [1:0] PWR_SNOOZE = 2'h1;
    localparam logic [1:0] PWR_NORMAL = 2'h2;

    // Chained move numbers of the transfer engine.
    localparam logic [1:0] MOVE_CH0 = 2'h0;
    localparam logic [1:0] MOVE_CH1 = 2'h1;
    localparam logic [1:0] MOVE_THRESH = 2'h2;
    localparam logic [1:0] MOVE_CMP_IN = 2'h3;

    typedef enum {
        ST_STANDBY,
        ST_CONVERT,
        ST_XFER,
        ST_DUMP,
        ST_REARM
    } seq_state_t;

endpackage

// file: dv/snooze_seq_props.sv
`timescale 1ns/100ps
// Port-level checks of the snooze sequencer.
module snooze_seq_props
    import snooze_seq_pkg::*;
(
    input wire logic sys_clk_i, input wire logic reset_i, input wire logic calendar_present_i,
    input wire logic trig_on_snooze_req_i, input wire logic [EV_N-1:0] cpu_irq_enable_i,
    input wire logic xfer_trig_enable_i, input wire logic button_irq_i, input wire logic conv_start_o,
    input wire logic conv_end_i, input wire logic [SAMPLE_W-1:0] ch1_result_i, input wire logic tx_valid_o,
    input wire logic [SAMPLE_W-1:0] tx_data_o, input wire logic tx_ready_i, input wire logic [1:0] power_state_o,
    input wire logic transfer_done_event_o, input wire logic level_hit_o,
    input wire logic [SAMPLE_W-1:0] cmp_setting_o, input wire logic [EV_N-1:0] cpu_irq_o,
    input wire logic alarm_rearm_o, input wire logic timer_output_pin_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (reset_i);
    // Conversion follows snooze entry, directly or one cycle later.
    start_on_entry_a: assert property (power_state_o == PWR_SNOOZE && $past(power_state_o) == PWR_STANDBY
        |-> if (trig_on_snooze_req_i) (##1 conv_start_o) else conv_start_o) else $error("no conversion start");
    start_in_snooze_a: assert property (conv_start_o |-> power_state_o == PWR_SNOOZE ##1 !conv_start_o)
        else $error("stray conversion start");
    chain_length_a: assert property (conv_end_i && xfer_trig_enable_i && power_state_o == PWR_SNOOZE
        |-> ##5 transfer_done_event_o) else $error("transfer end late");
    end_state_a: assert property (transfer_done_event_o
        |-> power_state_o == (level_hit_o ? PWR_NORMAL : PWR_STANDBY)) else $error("wrong state after transfer");
    level_judge_a: assert property (transfer_done_event_o
        |-> level_hit_o == ($past(ch1_result_i, 5) >= cmp_setting_o)) else $error("wrong level judgement");
    tx_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
        else $error("transmit word dropped");
    rearm_sleep_a: assert property (alarm_rearm_o |-> power_state_o == PWR_NORMAL && !tx_valid_o ##1 power_state_o == PWR_STANDBY)
        else $error("no standby after rearm");
    button_wake_a: assert property ($rose(button_irq_i) && power_state_o == PWR_STANDBY
        |=> power_state_o == PWR_NORMAL) else $error("button did not wake");
    irq_route_a: assert property (conv_end_i && cpu_irq_enable_i[EV_CONV_END] && power_state_o == PWR_SNOOZE
        |=> cpu_irq_o[EV_CONV_END]) else $error("conversion irq missing");
    irq_mask_a: assert property (!cpu_irq_enable_i[EV_XFER_DONE] |=> !cpu_irq_o[EV_XFER_DONE])
        else $error("masked irq raised");
    pin_pulse_a: assert property (timer_output_pin_o |-> !calendar_present_i ##1 !timer_output_pin_o)
        else $error("bad daily pin pulse");
endmodule
bind snooze_acquisition_sequencer snooze_seq_props chk (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
    .calendar_present_i(calendar_present_i), .trig_on_snooze_req_i(trig_on_snooze_req_i),
    .cpu_irq_enable_i(cpu_irq_enable_i), .xfer_trig_enable_i(xfer_trig_enable_i), .button_irq_i(button_irq_i),
    .conv_start_o(conv_start_o), .conv_end_i(conv_end_i), .ch1_result_i(ch1_result_i), .tx_valid_o(tx_valid_o),
    .tx_data_o(tx_data_o), .tx_ready_i(tx_ready_i), .power_state_o(power_state_o),
    .transfer_done_event_o(transfer_done_event_o), .level_hit_o(level_hit_o), .cmp_setting_o(cmp_setting_o),
    .cpu_irq_o(cpu_irq_o), .alarm_rearm_o(alarm_rearm_o), .timer_output_pin_o(timer_output_pin_o));

// file: dv/sensor_uart_model.sv
`timescale 1ns/100ps
// Far side: a two-channel converter that ends a conversion after a random wait,
// and a serial receiver that stalls at random.
module sensor_uart_model
    import snooze_seq_pkg::*;
(
    // Clock.
    input wire logic sys_clk_i,
    // Converter side.
    input wire logic conv_start_i,
    input wire logic [SAMPLE_W-1:0] smp0_i,
    input wire logic [SAMPLE_W-1:0] smp1_i,
    output logic conv_end_o,
    output logic [SAMPLE_W-1:0] ch0_o,
    output logic [SAMPLE_W-1:0] ch1_o,
    // Receiver side.
    output logic ready_o
);
    logic start;
    int wait_n = 0;
    // Result lines carry junk outside the end pulse so stale values never pass.
    initial begin
        conv_end_o = 1'b0;
        ch0_o = 12'h000;
        ch1_o = 12'h000;
        ready_o = 1'b0;
        forever begin
            @(posedge sys_clk_i);
            #1;
            // The start pulse launched at this edge is read once it has settled.
            start = conv_start_i;
            ready_o = 1'($urandom);
            conv_end_o = (wait_n == 1);
            ch0_o = (wait_n == 1) ? smp0_i : ~ch0_o;
            ch1_o = (wait_n == 1) ? smp1_i : ~ch1_o;
            if (wait_n != 0) wait_n--;
            if (start) wait_n = 2 + $urandom_range(3);
        end
    end
endmodule

// file: dv/test_snooze_acquisition_sequencer.sv
`timescale 1ns/100ps
// Self-checking bench for the snooze acquisition sequencer.
module test_snooze_acquisition_sequencer;
    import snooze_seq_pkg::*;
    localparam int PS = 4;
    localparam int WIDE_GAP = 20 * PS;
    localparam int CASC_GAP = int'(HALF_HOUR_COUNTS) * 4 * PS;
    logic sys_clk_i = 1'b0, reset_i = 1'b1, wide = 1'b1, cal = 1'b1, trig_on = 1'b0, xfer_en = 1'b1;
    logic alarm = 1'b0, button = 1'b0, force_hit = 1'b0, dump_chk = 1'b1, e;
    logic [EV_N-1:0] irq_en = 7'h7f;
    logic [SAMPLE_W-1:0] thr = 12'h800, smp0 = 12'h000, smp1 = 12'h000, ch0, ch1, tx_data, cmp_set;
    logic conv_start, conv_end, tx_valid, tx_ready, done_ev, hit, rearm, pin;
    logic [1:0] pstate;
    logic [EV_N-1:0] irq;
    logic exp_q[$];
    logic [SAMPLE_W-1:0] words[$];
    int error_cnt = 0, check_count = 0, cyc = 0, starts = 0, last_start = 0, gap = 0, rearms = 0, s0;
    always #4 sys_clk_i = ~sys_clk_i;
    // The daily pin is looped back to the second external interrupt line.
    snooze_acquisition_sequencer #(.PRESCALE(17'h4), .MINUTE_LEN(16'h4), .WIDE_LEN(32'h14), .DAILY_LEN(32'h1f4)) dut (
        .sys_clk_i(sys_clk_i), .reset_i(reset_i), .wide_timer_mode_i(wide), .calendar_present_i(cal),
        .trig_on_snooze_req_i(trig_on), .cpu_irq_enable_i(irq_en), .xfer_trig_enable_i(xfer_en), .alarm_i(alarm),
        .button_irq_i(button), .external_interrupt_line_two_i(pin), .conv_start_o(conv_start), .conv_end_i(conv_end),
        .ch0_result_i(ch0), .ch1_result_i(ch1), .threshold_i(thr), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_ready_i(tx_ready), .power_state_o(pstate), .transfer_done_event_o(done_ev), .level_hit_o(hit),
        .cmp_setting_o(cmp_set), .cpu_irq_o(irq), .alarm_rearm_o(rearm), .timer_output_pin_o(pin));
    sensor_uart_model far (.sys_clk_i(sys_clk_i), .conv_start_i(conv_start), .smp0_i(smp0), .smp1_i(smp1),
        .conv_end_o(conv_end), .ch0_o(ch0), .ch1_o(ch1), .ready_o(tx_ready));
    task automatic check(input string what, input logic [SAMPLE_W-1:0] seen, input logic [SAMPLE_W-1:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask
    task automatic wait_mode(input logic [1:0] m, input int lim);
        for (int i = 0; i < lim && pstate !== m; i++) step(1);
        check("power state", 12'(pstate), 12'(m));
    endtask
    task automatic wait_starts(input int n, input int lim);
        int target;
        target = starts + n;
        for (int i = 0; i < lim && starts < target; i++) step(1);
        check("snooze starts", 12'(starts >= target), 12'h1);
    endtask
    // Wake from standby by button or alarm, then let the dump finish.
    task automatic wake(input bit by_alarm);
        wait_mode(PWR_STANDBY, 400);
        if (by_alarm) alarm = 1'b1;
        else button = 1'b1;
        step(1);
        alarm = 1'b0;
        wait_mode(PWR_NORMAL, 2);
        button = 1'b0;
        wait_mode(PWR_STANDBY, 400);
    endtask
    // Note what each taken conversion must produce, then compare when results appear.
    always @(negedge sys_clk_i) begin
        cyc++;
        if (conv_start === 1'b1) begin
            gap = cyc - last_start;
            last_start = cyc;
            starts++;
            smp0 = 12'($urandom);
            smp1 = force_hit ? thr : 12'($urandom) & 12'h7ff;
        end
        if (conv_end && pstate === PWR_SNOOZE && xfer_en) begin
            exp_q.push_back(ch1 >= thr);
            words.push_back(ch0);
            words.push_back(ch1);
        end
        if (done_ev === 1'b1) begin
            e = (exp_q.size() != 0) ? exp_q.pop_front() : 1'bx;
            check("level hit", 12'(hit), 12'(e));
            check("state after transfer", 12'(pstate), 12'(e ? PWR_NORMAL : PWR_STANDBY));
            check("threshold copy", cmp_set, thr);
        end
        if (tx_valid === 1'b1 && tx_ready === 1'b1 && dump_chk) begin
            check("dump word", tx_data, (words.size() != 0) ? words.pop_front() : 12'hxxx);
        end
        if (rearm === 1'b1) rearms++;
    end
    task automatic final_report();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    initial begin
        #96000;
        error_cnt++;
        final_report();
    end
    initial begin
        void'($urandom(32'hebdc));
        irq_en = 7'($urandom) | 7'h01;
        step(3);
        reset_i = 1'b0;
        wait_starts(3, 300);
        check("wide period", 12'(gap), 12'(WIDE_GAP));
        // Conversion started from the registered snooze request event.
        wait_mode(PWR_STANDBY, 100);
        trig_on = 1'b1;
        wait_starts(1, 200);
        wait_mode(PWR_STANDBY, 100);
        trig_on = 1'b0;
        // A sample equal to the threshold wakes the device and dumps the buffer.
        force_hit = 1'b1;
        wait_mode(PWR_NORMAL, 200);
        force_hit = 1'b0;
        wait_mode(PWR_STANDBY, 400);
        check("words left", 12'(words.size()), 12'h000);
        dump_chk = 1'b0;
        irq_en = 7'($urandom) | 7'h01;
        wake(1'b0);
        wake(1'b1);
        check("rearm pulses", 12'(rearms), 12'h001);
        // With the transfer trigger masked the snooze holds and later requests are dropped.
        xfer_en = 1'b0;
        wait_starts(1, 200);
        s0 = starts;
        step(200);
        check("restarts", 12'(starts - s0), 12'h000);
        check("held in snooze", 12'(pstate), 12'(PWR_SNOOZE));
        button = 1'b1;
        step(1);
        wait_mode(PWR_NORMAL, 2);
        button = 1'b0;
        xfer_en = 1'b1;
        wait_mode(PWR_STANDBY, 400);
        wide = 1'b0;
        wait_starts(3, 1600);
        check("cascade period", 12'(gap), 12'(CASC_GAP));
        cal = 1'b0;
        wait_mode(PWR_NORMAL, 4200);
        wait_mode(PWR_STANDBY, 400);
        final_report();
    end
endmodule
